// ==== inc/shreg_pkg.sv ====
package shreg_pkg;

    // ------------------------------------------------------------------
    // widths and depths
    // ------------------------------------------------------------------
    localparam int unsigned WIDTH = 4;   // stages in the register
    localparam int unsigned DEPTH = 2;   // words held by the output buffer
    localparam int unsigned PTR_W = 1;   // buffer pointer width
    localparam int unsigned CNT_W = 2;   // buffer fill count width

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [WIDTH-1:0] STAGE_RST = 4'h0;
    localparam logic             INV_RST   = 1'h1;
    localparam logic [PTR_W-1:0] PTR_RST   = 1'h0;
    localparam logic [CNT_W-1:0] CNT_RST   = 2'h0;
    localparam logic [PTR_W-1:0] PTR_ONE   = 1'h1;
    localparam logic [CNT_W-1:0] CNT_ONE   = 2'h1;
    localparam logic [CNT_W-1:0] CNT_FULL  = 2'h2;

    // ------------------------------------------------------------------
    // operating modes, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_HOLD  = 3'b001,
        MODE_LOAD  = 3'b010,
        MODE_SHIFT = 3'b100
    } mode_t;

endpackage

// ==== rtl/four_bit_universal_shift_register.sv ====
// Summary of operation
// - with the enable input high at a clock edge the register keeps its contents.
// - with enable low and load select low each stage loads its own parallel input.
// - with enable low and load select high the register shifts, stage 0 taking serial_in.
// - outputs change only after a rising clock edge, apart from the clear.
// - mode, parallel and serial inputs matter only as sampled at the rising edge.
// - a low clear_n empties the register at once, outputs low and inverted output high.
`timescale 1ns/1ns
module four_bit_universal_shift_register (
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    input  wire logic                     clear_n,
    input  wire logic                     clk_en,
    input  wire logic                     en_n,
    input  wire logic                     load_sel_n,
    input  wire logic                     par_in_0,
    input  wire logic                     par_in_1,
    input  wire logic                     par_in_2,
    input  wire logic                     par_in_3,
    input  wire logic                     serial_in,
    output logic                          stage_out_0,
    output logic                          stage_out_1,
    output logic                          stage_out_2,
    output logic                          stage_out_3,
    output logic                          last_stage_inv,
    output logic                          in_ready,
    output logic [shreg_pkg::WIDTH-1:0]   word_data,
    output logic                          word_valid,
    input  wire logic                     word_ready
);
    import shreg_pkg::*;

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    // shared by the datapath and the checks below
    function automatic mode_t decode_mode(input logic e_n, input logic l_n);
        mode_t m;
        m = MODE_HOLD;
        if (e_n) begin
            m = MODE_HOLD;
        end else if (!l_n) begin
            m = MODE_LOAD;
        end else begin
            m = MODE_SHIFT;
        end
        return m;
    endfunction

    logic [WIDTH-1:0] par_vec;
    logic [WIDTH-1:0] stage_q;
    logic [WIDTH-1:0] stage_d;
    logic             inv_q;
    logic             inv_d;
    logic [WIDTH-1:0] shift_vec;
    mode_t            mode;
    logic             update;
    logic [WIDTH-1:0] buf_mem_q [DEPTH];
    logic [WIDTH-1:0] buf_mem_d [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] wr_ptr_d;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [PTR_W-1:0] rd_ptr_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             push;
    logic             pop;

    // load select sampled as active low
    assign par_vec  = {par_in_3, par_in_2, par_in_1, par_in_0};
    assign mode     = decode_mode(en_n, load_sel_n);
    // a full buffer stalls the register so no snapshot is lost; a held
    // clear keeps the stages empty, so nothing it blocks is queued either
    assign in_ready = (cnt_q != CNT_FULL);
    assign update   = clk_en && in_ready && clear_n && (mode != MODE_HOLD);

    // ------------------------------------------------------------------
    // shift path
    // ------------------------------------------------------------------
    assign shift_vec[0] = serial_in;
    genvar gi;
    generate
        for (gi = 1; gi < WIDTH; gi++) begin : g_shift
            assign shift_vec[gi] = stage_q[gi-1];
        end
    endgenerate

    // next state of the stages
    always_comb begin
        stage_d = stage_q;
        if (!rst_n) begin
            stage_d = STAGE_RST;
        end else if (clk_en && in_ready) begin
            case (mode)
                MODE_LOAD: begin
                    stage_d = par_vec;
                end
                MODE_SHIFT: begin
                    stage_d = shift_vec;
                end
                default: begin
                    stage_d = stage_q;
                end
            endcase
        end
        inv_d = ~stage_d[WIDTH-1];
    end

    // clear_n acts without the clock, other inputs only at the edge
    always_ff @(posedge mclk or negedge clear_n) begin
        if (!clear_n) begin
            stage_q <= STAGE_RST;
            inv_q   <= INV_RST;
        end else begin
            stage_q <= stage_d;
            inv_q   <= inv_d;
        end
    end

    assign stage_out_0    = stage_q[0];
    assign stage_out_1    = stage_q[1];
    assign stage_out_2    = stage_q[2];
    assign stage_out_3    = stage_q[3];
    assign last_stage_inv = inv_q;

    // ------------------------------------------------------------------
    // two-entry output buffer
    // ------------------------------------------------------------------
    // every loaded or shifted value is queued for the reader
    assign push = update;
    assign pop  = clk_en && word_ready && (cnt_q != CNT_RST);

    always_comb begin
        buf_mem_d = buf_mem_q;
        wr_ptr_d  = wr_ptr_q;
        rd_ptr_d  = rd_ptr_q;
        cnt_d     = cnt_q;
        if (!rst_n) begin
            wr_ptr_d = PTR_RST;
            rd_ptr_d = PTR_RST;
            cnt_d    = CNT_RST;
        end else begin
            if (push) begin
                buf_mem_d[wr_ptr_q] = stage_d;
                wr_ptr_d            = wr_ptr_q + PTR_ONE;
            end
            if (pop) begin
                rd_ptr_d = rd_ptr_q + PTR_ONE;
            end
            if (push && !pop) begin
                cnt_d = cnt_q + CNT_ONE;
            end else if (pop && !push) begin
                cnt_d = cnt_q - CNT_ONE;
            end
        end
    end

    // buffer words are not cleared, only the pointers and the fill count
    always_ff @(posedge mclk) begin
        buf_mem_q <= buf_mem_d;
        wr_ptr_q  <= wr_ptr_d;
        rd_ptr_q  <= rd_ptr_d;
        cnt_q     <= cnt_d;
    end

    assign word_data  = buf_mem_q[rd_ptr_q];
    assign word_valid = (cnt_q != CNT_RST);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n || !clear_n);

    property p_hold;
        en_n && rst_n |=> $stable(stage_q);
    endproperty
    a_hold: assert property (p_hold) else $error("hold mode changed the stages");

    property p_load;
        update && (mode == MODE_LOAD) && rst_n |=> stage_q == $past(par_vec);
    endproperty
    a_load: assert property (p_load) else $error("parallel load mismatch");

    property p_shift_in;
        update && (mode == MODE_SHIFT) && rst_n |=> stage_q[0] == $past(serial_in);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("serial entry wrong");

    property p_shift_move;
        update && !en_n && load_sel_n && rst_n
            |=> stage_q[WIDTH-1:1] == $past(stage_q[WIDTH-2:0]);
    endproperty
    a_shift_move: assert property (p_shift_move) else $error("stages did not move up");

    property p_freeze;
        !clk_en && rst_n |=> $stable(stage_q) && $stable(cnt_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved without clock enable");

    property p_stall;
        !in_ready && rst_n |=> $stable(stage_q);
    endproperty
    a_stall: assert property (p_stall) else $error("register moved while buffer full");

    property p_inv;
        last_stage_inv == !stage_q[WIDTH-1];
    endproperty
    a_inv: assert property (p_inv) else $error("inverted output not complement");

    property p_clear;
        @(posedge mclk) disable iff (1'b0)
        !clear_n |-> (stage_q == STAGE_RST) && last_stage_inv;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not empty register");

    property p_queue;
        update && rst_n && !word_valid |=> word_valid && (word_data == stage_q);
    endproperty
    a_queue: assert property (p_queue) else $error("update not queued");

    c_load: cover property (update && (mode == MODE_LOAD));
    c_shift4: cover property ((update && (mode == MODE_SHIFT)) [*4]);
    c_full: cover property (!in_ready && !en_n ##[1:2] in_ready);
    c_clear: cover property (@(posedge mclk) disable iff (1'b0) !clear_n);

endmodule

// ==== verif/word_sink.sv ====
`timescale 1ns/1ns
module word_sink (
    input  wire logic                        mclk,
    input  wire logic                        stall,
    input  wire logic                        word_valid,
    input  wire logic [shreg_pkg::WIDTH-1:0] word_data,
    output logic                             word_ready,
    output logic      [shreg_pkg::WIDTH-1:0] last_word
);
    import shreg_pkg::*;
    // ready drops only while a scenario asks the reader to stall
    assign word_ready = !stall;
    // keep the last word popped, so order through the buffer can be judged
    always_ff @(posedge mclk) begin
        if (word_valid && word_ready) begin
            last_word <= word_data;
        end
    end
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/1ns
module testbench;
    import shreg_pkg::*;
    logic             mclk = 0, rst_n = 0, clear_n = 1, clk_en = 1;
    logic             en_n = 1, load_sel_n = 1, serial_in = 0, stall = 0;
    logic [WIDTH-1:0] par = 4'h0, m, p, last_word, word_data;
    logic             s0, s1, s2, s3, inv, in_ready, word_valid, word_ready;
    int               err_count = 0, n_checks = 0;
    wire  [WIDTH-1:0] st = {s3, s2, s1, s0};
    // ------------------------------------------------------------------
    // clock, design and reader
    // ------------------------------------------------------------------
    always #5 mclk = ~mclk;
    four_bit_universal_shift_register i_four_bit_universal_shift_register (
        .mclk(mclk), .rst_n(rst_n), .clear_n(clear_n), .clk_en(clk_en),
        .en_n(en_n), .load_sel_n(load_sel_n), .par_in_0(par[0]), .par_in_1(par[1]),
        .par_in_2(par[2]), .par_in_3(par[3]), .serial_in(serial_in),
        .stage_out_0(s0), .stage_out_1(s1), .stage_out_2(s2), .stage_out_3(s3),
        .last_stage_inv(inv), .in_ready(in_ready), .word_data(word_data),
        .word_valid(word_valid), .word_ready(word_ready));
    word_sink i_word_sink (.mclk(mclk), .stall(stall), .word_valid(word_valid),
        .word_data(word_data), .word_ready(word_ready), .last_word(last_word));
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task chk(input string name, input logic [WIDTH-1:0] exp, input logic [WIDTH-1:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // inputs change at the falling edge, so one rising edge acts per step
    task step(input logic e, input logic l, input logic [WIDTH-1:0] v, input logic s);
        en_n = e;
        load_sel_n = l;
        par = v;
        serial_in = s;
        @(negedge mclk);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task t_modes;
        step(0, 0, 4'hA, 0); chk("load", 4'hA, st);
        chk("inv", 4'h0, {3'h0, inv});
        step(0, 1, 4'h0, 1); chk("shift", 4'h5, st);
        chk("inv", 4'h1, {3'h0, inv});
        step(0, 1, 4'hF, 0); chk("shift", 4'hA, st);
        step(1, 0, 4'hF, 1); chk("hold", 4'hA, st);
        step(1, 1, 4'h3, 0); chk("hold", 4'hA, st);
        clk_en = 0;
        step(0, 0, 4'h6, 1); chk("frozen", 4'hA, st);
        clk_en = 1;
        $display("test modes done");
    endtask
    // four shifts carry a serial stream through every stage, parallel inputs ignored
    task t_serial;
        m = 4'h0;
        step(0, 0, 4'h0, 1); chk("serial start", 4'h0, st);
        for (int i = 0; i < 4; i++) begin
            m = {m[2:0], i[1] ^ 1'b1};
            step(0, 1, 4'hF, i[1] ^ 1'b1); chk("serial", m, st);
        end
        chk("serial inv", 4'h0, {3'h0, inv});
        $display("test serial done");
    endtask
    // clear acts before any rising edge and beats a load
    task t_clear;
        clear_n = 0;
        #2 chk("clear", 4'h0, st);
        chk("inv", 4'h1, {3'h0, inv});
        @(negedge mclk);
        step(0, 0, 4'hF, 0); chk("clear", 4'h0, st);
        clear_n = 1;
        $display("test clear done");
    endtask
    // outside wiring turns the load path into a shift toward stage 0
    task t_left;
        step(0, 0, 4'h9, 0);
        m = 4'h9;
        for (int i = 0; i < 4; i++) begin
            p = {i[0], st[3], st[2], st[1]};
            m = {i[0], m[3:1]};
            step(0, 0, p, i[0]); chk("left", m, st);
        end
        $display("test left done");
    endtask
    // reader stalls: two words fill the buffer, a third update must wait
    task t_buf;
        step(1, 0, 4'h0, 0);
        stall = 1;
        step(0, 0, 4'h3, 0);
        step(0, 0, 4'hC, 0);
        step(0, 0, 4'hF, 0); chk("stalled", 4'hC, st);
        chk("ready", 4'h0, {3'h0, in_ready});
        chk("head", 4'h3, word_data);
        stall = 0;
        step(1, 0, 4'h0, 0); chk("pop", 4'h3, last_word);
        @(negedge mclk); chk("pop", 4'hC, last_word);
        chk("valid", 4'h0, {3'h0, word_valid});
        $display("test buffer done");
    endtask
    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(negedge mclk);
        rst_n = 1;
        chk("reset", 4'h0, st);
        chk("reset inv", 4'h1, {3'h0, inv});
        t_modes;
        t_serial;
        t_clear;
        t_left;
        t_buf;
        wrap_up;
    end
    // the whole run is well under a hundred cycles
    initial begin
        #5000;
        err_count++;
        wrap_up;
    end
endmodule
